/* File: include/core_pkg.sv */
// Shared constants and carrier types of the integer and branch execution core
package core_pkg;
    localparam int XLEN = 32;
    localparam int BYTE_W = 8;
    localparam logic [31:0] INSN_BYTES = 32'h0000_0004;
    localparam logic [31:0] WORD_MASK = 32'hFFFF_FFFC;
    localparam logic [4:0] R_ZERO = 5'h00;
    localparam int XER_SO = 31;
    localparam int XER_OV = 30;
    localparam int XER_CA = 29;
    localparam int TC_LT = 0;
    localparam int TC_GT = 1;
    localparam int TC_EQ = 2;
    localparam int TC_LTU = 3;
    localparam int TC_GTU = 4;
    localparam logic [1:0] LANE_LAST = 2'h3;
    localparam logic [6:0] CNT_ONE = 7'h01;

    typedef enum logic [3:0] {
        OP_BRANCH = 4'h0, OP_SYSCALL = 4'h1, OP_CR_MOVE = 4'h2,
        OP_CR_LOGIC = 4'h3, OP_LOAD = 4'h4, OP_STORE = 4'h5,
        OP_STR_LOAD = 4'h6, OP_STR_STORE = 4'h7, OP_ADD = 4'h8,
        OP_CMP = 4'h9, OP_TRAP = 4'hA
    } op_kind_t;
    typedef enum logic [1:0] {
        TGT_REL = 2'h0, TGT_ABS = 2'h1, TGT_LINK = 2'h2, TGT_COUNT = 2'h3
    } tgt_mode_t;
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2
    } acc_size_t;
    typedef enum logic [1:0] {
        SPR_LINK = 2'h0, SPR_COUNT = 2'h1, SPR_MQ = 2'h2, SPR_XER = 2'h3
    } spr_sel_t;
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_MEM = 2'h1, ST_STR = 2'h2} core_state_t;

    typedef struct packed {
        op_kind_t kind;
        logic [31:0] pc;
        logic link_flag;
        tgt_mode_t tgt;
        logic [23:0] disp;
        logic cond_en;
        logic [4:0] cond_bit;
        logic cond_val;
        logic [4:0] destination_register;
        logic [4:0] first_source_register;
        logic [4:0] second_source_register;
        logic use_imm;
        logic imm_uns;
        logic [15:0] imm;
        logic logical;
        logic [2:0] crf_dst;
        logic [2:0] crf_src;
        logic [3:0] cr_func;
        acc_size_t size;
        logic update;
        logic [6:0] count;
        logic sub;
        logic oe;
        logic rc;
        logic [4:0] trap_condition_mask;
    } op_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        acc_size_t size;
        logic [31:0] wdata;
    } mem_req_t;
    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
        logic align_fault;
        logic dsi_fault;
    } mem_rsp_t;
    typedef struct packed {
        logic syscall;
        logic trap;
        logic align;
        logic dsi;
    } event_t;
    typedef struct packed {
        logic valid;
        logic [31:0] target;
    } redirect_t;
    typedef struct packed {
        logic valid;
        spr_sel_t sel;
        logic [31:0] data;
    } spr_load_t;
endpackage

/* File: hw/exec_core.sv */
// Integer and branch execution core: branch unit, condition logic, loads, stores, arithmetic, traps
// Summary of operation
// - Condition, link and count registers, 32 bits each.
// - Low two bits of every branch target are cleared.
// - Target: own address plus constant, absolute, link or count register.
// - Branches never check privilege.
// - Link flag set: link register gets address after the branch.
// - Link flag clear keeps link register; system call with flag also links.
// - System call raises an interrupt event.
// - Condition ops copy a four-bit field or combine two bits.
// - Thirty-two general registers, exception register, multiply-quotient on older variant.
// - Load puts addressed item in destination unless alignment or storage fault.
// - Store writes source item at effective address unless faulted.
// - Unaligned access completes in hardware or raises an alignment event.
// - Update form writes effective address back to the base register.
// - Older update loads skip write-back: base=dest, base zero, either fault.
// - Older update stores skip write-back: base zero or either fault.
// - Alignment event leaves base register without the effective address.
// - Zero-length string leaves destination alone; others ignore alignment.
// - Arithmetic treats operands as 32-bit two's complement.
// - Compare against signed, unsigned immediate or register, signed or unsigned.
// - Trap compares first source with sign-extended immediate or register, 32 bits.
// - Five trap conditions ANDed with mask; nonzero raises trap event.
// - Mask bits: signed lt, signed gt, eq, unsigned lt, unsigned gt.
`timescale 1ns/10ps
`default_nettype none
module exec_core
    import core_pkg::*;
#(
    parameter bit OLD_VARIANT = 1'b0,
    parameter bit HW_UNALIGNED = 1'b0,
    parameter int NUM_GR = 32
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic op_valid_i,
    input wire op_t op_i,
    output logic op_ready_o,
    input wire spr_load_t spr_load_i,
    output mem_req_t mem_req_o,
    input wire mem_rsp_t mem_rsp_i,
    output redirect_t redirect_o,
    output event_t events_o,
    input wire logic [4:0] gr_addr_i,
    output logic [31:0] gr_data_o,
    output logic [31:0] cr_o,
    output logic [31:0] lr_o,
    output logic [31:0] ctr_o,
    output logic [31:0] xer_o,
    output logic [31:0] mq_o
);
    if (NUM_GR != 32) begin : g_chk
        $error("exec_core serves exactly 32 general registers");
    end

    typedef struct packed {
        core_state_t st;
        op_t cur;
        logic [31:0] ea;
        logic [31:0][31:0] gr;
        logic [31:0] cr;
        logic [31:0] lr;
        logic [31:0] ctr;
        logic [31:0] fixed_point_exception_register;
        logic [31:0] mq;
        mem_req_t req;
        event_t ev;
        redirect_t redir;
        logic [6:0] left;
        logic [4:0] sreg;
        logic [1:0] lane;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    function automatic logic [4:0] cmp5(input logic [31:0] a, input logic [31:0] b);
        logic [4:0] c;
        c = '0;
        c[TC_LT] = $signed(a) < $signed(b);
        c[TC_GT] = $signed(a) > $signed(b);
        c[TC_EQ] = a == b;
        c[TC_LTU] = a < b;
        c[TC_GTU] = a > b;
        return c;
    endfunction

    function automatic logic misaligned(input logic [31:0] a, input acc_size_t sz);
        return (sz == SZ_HALF && a[0]) || (sz == SZ_WORD && a[1:0] != 2'h0);
    endfunction

    function automatic logic [7:0] lane_byte(input logic [31:0] w, input logic [1:0] ln);
        return w[{~ln, 3'h0} +: 8];
    endfunction

    function automatic logic [31:0] size_mask(input logic [31:0] w, input acc_size_t sz);
        unique case (sz)
            SZ_BYTE: return {24'h000000, w[7:0]};
            SZ_HALF: return {16'h0000, w[15:0]};
            default: return w;
        endcase
    endfunction

    logic [31:0] base_w;
    logic [31:0] opb_w;
    logic [31:0] ea_w;
    logic [31:0] rel_w;
    logic [31:0] abs_w;
    logic taken_w;
    logic [4:0] cond5_w;
    logic trap_hit_w;
    logic [3:0] cmp_nib_w;
    logic [32:0] sum_w;
    logic [31:0] opa_w;
    logic ov_w;
    logic acc_w;
    logic upd_ok_w;

    // Register zero as base reads as zero for address forming
    always_comb begin
        base_w = (op_i.first_source_register == R_ZERO) ? '0
                 : state_r.gr[op_i.first_source_register];
        opb_w = op_i.use_imm
                ? (op_i.imm_uns ? {16'h0000, op_i.imm} : {{16{op_i.imm[15]}}, op_i.imm})
                : state_r.gr[op_i.second_source_register];
        ea_w = base_w + opb_w;
        abs_w = {{6{op_i.disp[23]}}, op_i.disp, 2'h0};
        rel_w = op_i.pc + abs_w;
        taken_w = !op_i.cond_en || (state_r.cr[~op_i.cond_bit] == op_i.cond_val);
        cond5_w = cmp5(state_r.gr[op_i.first_source_register], opb_w);
        trap_hit_w = |(op_i.trap_condition_mask & cond5_w);
        cmp_nib_w = op_i.logical
                    ? {cond5_w[TC_LTU], cond5_w[TC_GTU], cond5_w[TC_EQ], state_r.fixed_point_exception_register[XER_SO]}
                    : {cond5_w[TC_LT], cond5_w[TC_GT], cond5_w[TC_EQ], state_r.fixed_point_exception_register[XER_SO]};
        opa_w = op_i.sub ? ~base_w : base_w;
        sum_w = {1'b0, opa_w} + {1'b0, opb_w} + {32'h0, op_i.sub};
        ov_w = (opa_w[31] == opb_w[31]) && (sum_w[31] != opb_w[31]);
        acc_w = op_valid_i && op_ready_o && ce_i;
        // Older variant drops write-back for base zero, and for loads onto the base
        if (OLD_VARIANT) begin
            upd_ok_w = (state_r.cur.first_source_register != R_ZERO)
                       && !(state_r.cur.kind == OP_LOAD
                            && state_r.cur.first_source_register
                               == state_r.cur.destination_register);
        end else begin
            upd_ok_w = 1'b1;
        end
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.ev = '0;
        state_nxt.redir = '0;
        unique case (state_r.st)
            ST_IDLE: begin
                if (spr_load_i.valid) begin
                    unique case (spr_load_i.sel)
                        SPR_LINK: state_nxt.lr = spr_load_i.data;
                        SPR_COUNT: state_nxt.ctr = spr_load_i.data;
                        SPR_MQ: state_nxt.mq = OLD_VARIANT ? spr_load_i.data : '0;
                        SPR_XER: state_nxt.fixed_point_exception_register = spr_load_i.data;
                    endcase
                end
                if (op_valid_i) begin
                    state_nxt.cur = op_i;
                    unique case (op_i.kind)
                        OP_BRANCH: begin
                            // No privilege input exists, so no branch can fault
                            state_nxt.redir.valid = taken_w;
                            unique case (op_i.tgt)
                                TGT_REL: state_nxt.redir.target = rel_w & WORD_MASK;
                                TGT_ABS: state_nxt.redir.target = abs_w & WORD_MASK;
                                TGT_LINK: state_nxt.redir.target = state_r.lr & WORD_MASK;
                                TGT_COUNT: state_nxt.redir.target = state_r.ctr & WORD_MASK;
                            endcase
                            if (op_i.link_flag) begin
                                state_nxt.lr = op_i.pc + INSN_BYTES;
                            end
                        end
                        OP_SYSCALL: begin
                            state_nxt.ev.syscall = 1'b1;
                            if (op_i.link_flag) begin
                                state_nxt.lr = op_i.pc + INSN_BYTES;
                            end
                        end
                        OP_CR_MOVE: begin
                            state_nxt.cr[{~op_i.crf_dst, 2'h0} +: 4] =
                                state_r.cr[{~op_i.crf_src, 2'h0} +: 4];
                        end
                        OP_CR_LOGIC: begin
                            state_nxt.cr[~op_i.destination_register] = op_i.cr_func[
                                {state_r.cr[~op_i.first_source_register],
                                 state_r.cr[~op_i.second_source_register]}];
                        end
                        OP_LOAD, OP_STORE: begin
                            state_nxt.ea = ea_w;
                            if (!HW_UNALIGNED && misaligned(ea_w, op_i.size)) begin
                                // Left for the software handler; base is not touched
                                state_nxt.ev.align = 1'b1;
                            end else begin
                                state_nxt.st = ST_MEM;
                                state_nxt.req.valid = 1'b1;
                                state_nxt.req.write = op_i.kind == OP_STORE;
                                state_nxt.req.addr = ea_w;
                                state_nxt.req.size = op_i.size;
                                state_nxt.req.wdata = size_mask(
                                    state_r.gr[op_i.destination_register], op_i.size);
                            end
                        end
                        OP_STR_LOAD, OP_STR_STORE: begin
                            // Byte steps never misalign, so any start address works
                            if (op_i.count != '0) begin
                                state_nxt.st = ST_STR;
                                state_nxt.ea = ea_w;
                                state_nxt.left = op_i.count;
                                state_nxt.sreg = op_i.destination_register;
                                state_nxt.lane = '0;
                                state_nxt.req.valid = 1'b1;
                                state_nxt.req.write = op_i.kind == OP_STR_STORE;
                                state_nxt.req.addr = ea_w;
                                state_nxt.req.size = SZ_BYTE;
                                state_nxt.req.wdata = {24'h000000, lane_byte(
                                    state_r.gr[op_i.destination_register], 2'h0)};
                            end
                        end
                        OP_ADD: begin
                            state_nxt.gr[op_i.destination_register] = sum_w[31:0];
                            state_nxt.fixed_point_exception_register[XER_CA] = sum_w[32];
                            if (op_i.oe) begin
                                state_nxt.fixed_point_exception_register[XER_OV] = ov_w;
                                state_nxt.fixed_point_exception_register[XER_SO] = state_r.fixed_point_exception_register[XER_SO] | ov_w;
                            end
                            if (op_i.rc) begin
                                state_nxt.cr[31:28] = {sum_w[31], !sum_w[31] && sum_w[31:0] != '0,
                                    sum_w[31:0] == '0, state_nxt.fixed_point_exception_register[XER_SO]};
                            end
                        end
                        OP_CMP: begin
                            state_nxt.cr[{~op_i.crf_dst, 2'h0} +: 4] = cmp_nib_w;
                        end
                        OP_TRAP: begin
                            state_nxt.ev.trap = trap_hit_w;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_MEM: begin
                if (mem_rsp_i.valid) begin
                    state_nxt.st = ST_IDLE;
                    state_nxt.req.valid = 1'b0;
                    if (mem_rsp_i.align_fault || mem_rsp_i.dsi_fault) begin
                        state_nxt.ev.align = mem_rsp_i.align_fault;
                        state_nxt.ev.dsi = mem_rsp_i.dsi_fault;
                    end else begin
                        if (state_r.cur.update && upd_ok_w) begin
                            state_nxt.gr[state_r.cur.first_source_register] = state_r.ea;
                        end
                        if (state_r.cur.kind == OP_LOAD) begin
                            state_nxt.gr[state_r.cur.destination_register] =
                                size_mask(mem_rsp_i.rdata, state_r.cur.size);
                        end
                    end
                end
            end
            ST_STR: begin
                if (mem_rsp_i.valid) begin
                    if (mem_rsp_i.align_fault || mem_rsp_i.dsi_fault) begin
                        state_nxt.st = ST_IDLE;
                        state_nxt.req.valid = 1'b0;
                        state_nxt.ev.align = mem_rsp_i.align_fault;
                        state_nxt.ev.dsi = mem_rsp_i.dsi_fault;
                    end else begin
                        // Big-endian packing; a fresh register starts from zero
                        if (state_r.cur.kind == OP_STR_LOAD) begin
                            if (state_r.lane == 2'h0) begin
                                state_nxt.gr[state_r.sreg] = '0;
                            end
                            state_nxt.gr[state_r.sreg][{~state_r.lane, 3'h0} +: 8] =
                                mem_rsp_i.rdata[7:0];
                        end
                        state_nxt.ea = state_r.ea + 32'h0000_0001;
                        state_nxt.lane = state_r.lane + 2'h1;
                        state_nxt.sreg = (state_r.lane == LANE_LAST) ? state_r.sreg + 5'h01
                                         : state_r.sreg;
                        state_nxt.left = state_r.left - CNT_ONE;
                        state_nxt.req.addr = state_nxt.ea;
                        state_nxt.req.wdata = {24'h000000, lane_byte(
                            state_r.gr[state_nxt.sreg], state_nxt.lane)};
                        if (state_r.left == CNT_ONE) begin
                            state_nxt.st = ST_IDLE;
                            state_nxt.req.valid = 1'b0;
                        end
                    end
                end
            end
            default: begin
                state_nxt.st = ST_IDLE;
                state_nxt.req.valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= '0;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end

    assign op_ready_o = state_r.st == ST_IDLE;
    assign mem_req_o = state_r.req;
    assign redirect_o = state_r.redir;
    assign events_o = state_r.ev;
    assign gr_data_o = state_r.gr[gr_addr_i];
    assign cr_o = state_r.cr;
    assign lr_o = state_r.lr;
    assign ctr_o = state_r.ctr;
    assign xer_o = state_r.fixed_point_exception_register;
    assign mq_o = state_r.mq;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    property p_word_target;
        redirect_o.valid |-> redirect_o.target[1:0] == 2'h0;
    endproperty
    a_word_target: assert property (p_word_target) else $error("branch target not word aligned");

    property p_rel_target;
        acc_w && op_i.kind == OP_BRANCH && op_i.tgt == TGT_REL && taken_w
        |=> redirect_o.valid && redirect_o.target == ($past(rel_w) & WORD_MASK);
    endproperty
    a_rel_target: assert property (p_rel_target) else $error("relative target wrong");

    property p_link_set;
        acc_w && op_i.kind == OP_BRANCH && op_i.link_flag |=> lr_o == $past(op_i.pc) + INSN_BYTES;
    endproperty
    a_link_set: assert property (p_link_set) else $error("link register not set");

    property p_link_keep;
        acc_w && op_i.kind == OP_BRANCH && !op_i.link_flag && !spr_load_i.valid |=> $stable(lr_o);
    endproperty
    a_link_keep: assert property (p_link_keep) else $error("link register changed");

    property p_syscall;
        acc_w && op_i.kind == OP_SYSCALL |=> events_o.syscall ##1 !events_o.syscall || !ce_i;
    endproperty
    a_syscall: assert property (p_syscall) else $error("system call event wrong");

    property p_trap;
        acc_w && op_i.kind == OP_TRAP |=> events_o.trap == $past(trap_hit_w);
    endproperty
    a_trap: assert property (p_trap) else $error("trap event mismatch");

    property p_compare;
        acc_w && op_i.kind == OP_CMP
        |=> cr_o[{~$past(op_i.crf_dst), 2'h0} +: 4] == $past(cmp_nib_w);
    endproperty
    a_compare: assert property (p_compare) else $error("compare field wrong");

    property p_zero_string;
        acc_w && op_i.kind == OP_STR_LOAD && op_i.count == '0
        |=> op_ready_o && !mem_req_o.valid
            && state_r.gr[$past(op_i.destination_register)]
               == $past(state_r.gr[op_i.destination_register]);
    endproperty
    a_zero_string: assert property (p_zero_string) else $error("empty string changed state");

    property p_fault_keeps_base;
        ce_i && state_r.st == ST_MEM && mem_rsp_i.valid
        && (mem_rsp_i.align_fault || mem_rsp_i.dsi_fault)
        |=> state_r.gr[$past(state_r.cur.first_source_register)]
            == $past(state_r.gr[state_r.cur.first_source_register]);
    endproperty
    a_fault_keeps_base: assert property (p_fault_keeps_base) else $error("base updated on fault");
endmodule
`default_nettype wire

/* File: tb/storage_model.sv */
// Storage partner: word memory, random answer delay, injected storage faults
`timescale 1ns/10ps
`default_nettype none
module storage_model
    import core_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire mem_req_t req_i,
    input wire logic dsi_i,
    output mem_rsp_t rsp_o
);
    logic [31:0] mem [0:63];
    logic [1:0] wait_r;
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_o <= '0;
            wait_r <= 2'h0;
        end else begin
            rsp_o.valid <= 1'b0;
            rsp_o.dsi_fault <= 1'b0;
            // Idle data lines toggle so a stale word never passes for an answer
            rsp_o.rdata <= ~rsp_o.rdata;
            if (req_i.valid && !rsp_o.valid) begin
                if (wait_r != 2'h0) begin
                    wait_r <= wait_r - 2'h1;
                end else begin
                    rsp_o.valid <= 1'b1;
                    rsp_o.dsi_fault <= dsi_i;
                    rsp_o.rdata <= mem[req_i.addr[7:2]];
                    if (req_i.write && !dsi_i) begin
                        mem[req_i.addr[7:2]] <= req_i.wdata;
                    end
                    wait_r <= 2'($urandom_range(2, 0));
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/integer_branch_execution_core_tb.sv */
// Self-checking bench of the integer and branch execution core
`timescale 1ns/10ps
`default_nettype none
module integer_branch_execution_core_tb;
    import core_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic op_valid_i = 1'b0;
    op_t op_i = '0;
    spr_load_t spr_load_i = '0;
    logic [4:0] gr_addr_i = 5'h00;
    logic dsi_i = 1'b0;
    logic op_ready_o;
    mem_req_t mem_req_o;
    mem_rsp_t mem_rsp_i;
    redirect_t redirect_o;
    event_t events_o;
    event_t ev;
    logic [31:0] gr_data_o, cr_o, lr_o, ctr_o, xer_o, mq_o, t, lr0, v;
    int err_count = 0;
    int check_count = 0;
    int seed;
    op_t o;
    always #5 clock_i = ~clock_i;
    exec_core exec_core_inst (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
        .op_valid_i(op_valid_i), .op_i(op_i), .op_ready_o(op_ready_o),
        .spr_load_i(spr_load_i), .mem_req_o(mem_req_o), .mem_rsp_i(mem_rsp_i),
        .redirect_o(redirect_o), .events_o(events_o), .gr_addr_i(gr_addr_i),
        .gr_data_o(gr_data_o), .cr_o(cr_o), .lr_o(lr_o), .ctr_o(ctr_o), .xer_o(xer_o),
        .mq_o(mq_o));
    storage_model storage_model_inst (.clock_i(clock_i), .rst_i(rst_i), .req_i(mem_req_o),
        .dsi_i(dsi_i), .rsp_o(mem_rsp_i));
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic cg(input logic [4:0] r, input logic [31:0] exp);
        gr_addr_i = r;
        #1;
        chk("general_register", exp, gr_data_o);
    endtask
    // Waits are bounded; a stuck core ends the run as a failure
    task automatic issue(input op_t x);
        int n;
        n = 0;
        @(negedge clock_i);
        op_i = x;
        op_valid_i = 1'b1;
        while (op_ready_o !== 1'b1 && n < 40) begin
            @(negedge clock_i);
            n++;
        end
        if (n >= 40) begin
            err_count++;
            wrap_up();
        end
        @(negedge clock_i);
        op_valid_i = 1'b0;
        ev = events_o;
    endtask
    task automatic idle();
        int n;
        n = 0;
        while (op_ready_o !== 1'b1) begin
            @(negedge clock_i);
            ev = ev | events_o;
            n++;
            if (n > 40) begin
                err_count++;
                wrap_up();
            end
        end
    endtask
    function automatic op_t mk(input op_kind_t k, input logic [4:0] rt, input logic [4:0] ra,
        input logic [15:0] im);
        op_t x;
        x = '0;
        x.kind = k;
        x.destination_register = rt;
        x.first_source_register = ra;
        x.imm = im;
        x.use_imm = 1'b1;
        x.size = SZ_WORD;
        return x;
    endfunction
    function automatic logic tex(input logic [4:0] m, input logic [31:0] p, input logic [31:0] q);
        logic [4:0] c;
        c = {p > q, p < q, p == q, $signed(p) > $signed(q), $signed(p) < $signed(q)};
        return |(m & c);
    endfunction
    function automatic logic [31:0] tgt(input op_t x, input logic [31:0] l, input logic [31:0] c);
        logic [31:0] d;
        d = {{6{x.disp[23]}}, x.disp, 2'h0};
        case (x.tgt)
            TGT_REL: return (x.pc + d) & WORD_MASK;
            TGT_ABS: return d & WORD_MASK;
            TGT_LINK: return l & WORD_MASK;
            default: return c & WORD_MASK;
        endcase
    endfunction
    initial begin
        seed = $urandom(9971);
        repeat (16) @(posedge clock_i);
        @(negedge clock_i);
        rst_i = 1'b0;
        chk("ready", 32'h1, {31'h0, op_ready_o});
        chk("link_register", 32'h0, lr_o);
        for (int i = 1; i < 64; i++) storage_model_inst.mem[i] = $urandom;
        storage_model_inst.mem[10] = 32'h0000_0040;
        for (int i = 1; i < 11; i++) begin
            issue(mk(OP_LOAD, 5'(i), R_ZERO, 16'(i * 4)));
            idle();
            cg(5'(i), storage_model_inst.mem[i]);
        end
        for (int k = 0; k < 12; k++) begin
            spr_load_i = '{valid: 1'b1, sel: SPR_COUNT, data: $urandom};
            @(negedge clock_i);
            spr_load_i.valid = 1'b0;
            o = mk(OP_BRANCH, R_ZERO, R_ZERO, 16'h0000);
            o.tgt = tgt_mode_t'(k % 4);
            o.pc = $urandom;
            o.disp = 24'($urandom);
            o.link_flag = 1'($urandom);
            lr0 = lr_o;
            t = tgt(o, lr0, ctr_o);
            issue(o);
            chk("redirect valid", 32'h1, {31'h0, redirect_o.valid});
            chk("target", t, redirect_o.target);
            chk("link_register", o.link_flag ? o.pc + INSN_BYTES : lr0, lr_o);
        end
        o = mk(OP_SYSCALL, R_ZERO, R_ZERO, 16'h0000);
        o.pc = $urandom & WORD_MASK;
        o.link_flag = 1'b1;
        issue(o);
        chk("syscall", 32'h1, {31'h0, ev.syscall});
        chk("link_register", o.pc + INSN_BYTES, lr_o);
        issue(mk(OP_ADD, 5'h08, 5'h01, 16'h8000));
        cg(5'h08, storage_model_inst.mem[1] + 32'hFFFF_8000);
        o = mk(OP_ADD, 5'h09, 5'h02, 16'h0000);
        o.use_imm = 1'b0;
        o.second_source_register = 5'h03;
        issue(o);
        cg(5'h09, storage_model_inst.mem[2] + storage_model_inst.mem[3]);
        t = storage_model_inst.mem[1];
        v = {$signed(t) < -32768, $signed(t) > -32768, t == 32'hFFFF_8000, 29'h0};
        issue(mk(OP_CMP, R_ZERO, 5'h01, 16'h8000));
        chk("condition_register", v, cr_o);
        for (int m = 0; m < 32; m++) begin
            o = mk(OP_TRAP, R_ZERO, R_ZERO, 16'hFFFF);
            o.trap_condition_mask = 5'(m);
            issue(o);
            chk("trap", {31'h0, tex(5'(m), 32'h0, 32'hFFFF_FFFF)}, {31'h0, ev.trap});
        end
        for (int b = 0; b < 5; b++) begin
            o = mk(OP_TRAP, R_ZERO, 5'(b + 1), 16'h0000);
            o.use_imm = 1'b0;
            o.second_source_register = 5'((b == 2) ? 3 : b + 2);
            o.trap_condition_mask = 5'(1 << b);
            t = storage_model_inst.mem[o.second_source_register];
            v = {31'h0, tex(o.trap_condition_mask, storage_model_inst.mem[b + 1], t)};
            issue(o);
            chk("trap", v, {31'h0, ev.trap});
        end
        issue(mk(OP_STORE, 5'h01, R_ZERO, 16'h0080));
        idle();
        chk("storage", storage_model_inst.mem[1], storage_model_inst.mem[32]);
        o = mk(OP_LOAD, 5'h0B, 5'h0A, 16'h0004);
        o.update = 1'b1;
        issue(o);
        idle();
        cg(5'h0B, storage_model_inst.mem[17]);
        cg(5'h0A, 32'h0000_0044);
        o.destination_register = 5'h0C;
        o.imm = 16'h0002;
        issue(o);
        chk("align", 32'h1, {31'h0, ev.align});
        idle();
        cg(5'h0A, 32'h0000_0044);
        cg(5'h0C, 32'h0);
        dsi_i = 1'b1;
        o.destination_register = 5'h0D;
        o.imm = 16'h0000;
        issue(o);
        idle();
        dsi_i = 1'b0;
        chk("dsi", 32'h1, {31'h0, ev.dsi});
        cg(5'h0D, 32'h0);
        cg(5'h0A, 32'h0000_0044);
        issue(mk(OP_STR_LOAD, 5'h01, R_ZERO, 16'h0000));
        cg(5'h01, storage_model_inst.mem[1]);
        wrap_up();
    end
endmodule
`default_nettype wire
